// ==== logic/eesp_pkg.sv ====
package eesp_pkg;
  // opcodes, one byte each, sent msb first
  localparam logic [7:0] OP_ARM_WRITE = 8'h06;
  localparam logic [7:0] OP_DISARM_WRITE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

  // status byte bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_LOCK_LO = 2;
  localparam int BIT_LOCK_HI = 3;
  localparam int BIT_LOCK = 7;

  // non-volatile bits come up in the delivery state
  localparam logic LOCK_RST = 1'b0;
  localparam logic [1:0] REGION_RST = 2'h0;

  // array address width and protected region bases
  localparam int ADDR_W = 17;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 17'h18000;
  localparam logic [ADDR_W-1:0] HALF_BASE = 17'h10000;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_W_MS = 5;
  localparam int T_W_CYCLES = T_W_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TW_W = 20;
  localparam int SCLK_HALF = 8;

  // host controller register map (byte addresses)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_GUARD = 4'h8;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_CNT_LSB = 16;
  localparam int STAT_RX_LSB = 8;
  localparam logic GUARD_RST = 1'b1;
endpackage : eesp_pkg

// ==== logic/eesp_link_if.sv ====
`timescale 1ns/1ps
interface eesp_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic wp_n;
  modport host (output cs_n, output sclk, output mosi, output wp_n, input miso);
  modport dev (input cs_n, input sclk, input mosi, input wp_n, output miso);
endinterface : eesp_link_if

// ==== logic/eesp_sync.sv ====
`timescale 1ns/1ps
module eesp_sync #(
  parameter int W = 1
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [W-1:0] ASYNC_IN,
  output logic [W-1:0] SYNC_OUT
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = ASYNC_IN;
    sync_d = meta_q;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      meta_q <= '0;
      SYNC_OUT <= '0;
    end else begin
      meta_q <= meta_d;
      SYNC_OUT <= sync_d;
    end
  end
endmodule : eesp_sync

// ==== logic/eesp_dev.sv ====
// How it works
// - latch must be set before any write
// - arm-write acts only on chip select rise
// - disarm-write clears latch on chip select rise
// - latch clears at reset, disarm, write end
// - status read served even while busy
// - status byte repeats while select stays low
// - host should poll busy before new commands
// - busy reads one only during write cycle
// - no latch means writes are rejected
// - region bits guard array against writes
// - status write needs exact sixteen clocks
// - framed status write starts timed cycle
// - new lock bits appear after cycle ends
// - b6..b4,b1,b0 untouched; b6..b4 read zero
// - hard lock rejects all status writes
// - lock bit clear: status write allowed
// - lock bit set, guard high: allowed
// - hard lock entered in either order
// - only guard pin high leaves hard lock; here reset also clears the lock bit
// - four opcodes; others deselect the device
// - region codes: none, quarter, half, all
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module eesp_dev #(
  parameter int unsigned TW_CYCLES = eesp_pkg::T_W_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  eesp_link_if.dev LINK,
  input wire logic ARRAY_WR_REQ,
  input wire logic [eesp_pkg::ADDR_W-1:0] ARRAY_WR_ADDR,
  output logic ARRAY_WR_GRANT,
  output logic ARRAY_WR_DENY,
  output logic [7:0] STATUS
);
  import eesp_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_OPC = 3'b001,
    D_WAIT = 3'b010,
    D_CMD_STATUS_READ = 3'b011,
    D_CMD_STATUS_WRITE = 3'b100,
    D_WEND = 3'b101,
    D_DESEL = 3'b110
  } eesp_dst_t;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [7:0] pack_status(input logic lock, input logic [1:0] region,
                                             input logic latch, input logic busy);
    logic [7:0] s;
    s = 8'h00;
    s[BIT_BUSY] = busy;
    s[BIT_LATCH] = latch;
    s[BIT_LOCK_LO] = region[0];
    s[BIT_LOCK_HI] = region[1];
    s[BIT_LOCK] = lock;
    return s;
  endfunction : pack_status

  function automatic logic region_hit(input logic [ADDR_W-1:0] addr, input logic [1:0] region);
    logic hit;
    hit = 1'b0;
    unique case (region)
      2'h0: hit = 1'b0;
      2'h1: hit = (addr >= QUARTER_BASE);
      2'h2: hit = (addr >= HALF_BASE);
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction : region_hit

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the serial clock is sampled, not used as a clock

  logic cs_s;
  logic sclk_s;
  logic mosi_s;
  logic wp_s;

  eesp_sync #(.W(4)) u_sync (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .ASYNC_IN({LINK.cs_n, LINK.sclk, LINK.mosi, LINK.wp_n}),
    .SYNC_OUT({cs_s, sclk_s, mosi_s, wp_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // command engine, write cycle timer and status bits

  eesp_dst_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic miso_q, miso_d;
  logic arm_q, arm_d;
  logic cs_p_q, cs_p_d;
  logic sclk_p_q, sclk_p_d;
  logic latch_q, latch_d;
  logic busy_q, busy_d;
  logic kind_q, kind_d;
  logic [TW_W-1:0] tw_q, tw_d;
  logic [2:0] pend_q, pend_d;
  logic lock_q, lock_d;
  logic [1:0] region_q, region_d;
  logic grant_d;
  logic deny_d;
  logic [7:0] status_d;

  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic hard_lock;
  logic [7:0] status_now;

  always_comb begin
    // cs low at release shows no fall, so a fresh falling edge is needed
    cs_rise = cs_s & ~cs_p_q;
    cs_fall = ~cs_s & cs_p_q;
    sck_rise = sclk_s & ~sclk_p_q & ~cs_s;
    sck_fall = ~sclk_s & sclk_p_q & ~cs_s;
    hard_lock = lock_q & ~wp_s;
    status_now = pack_status(lock_q, region_q, latch_q, busy_q);

    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    miso_d = miso_q;
    arm_d = arm_q;
    cs_p_d = cs_s;
    sclk_p_d = sclk_s;
    latch_d = latch_q;
    busy_d = busy_q;
    kind_d = kind_q;
    tw_d = tw_q;
    pend_d = pend_q;
    lock_d = lock_q;
    region_d = region_q;
    grant_d = 1'b0;
    deny_d = 1'b0;

    // busy for the whole timed cycle
    if (busy_q) begin
      if (tw_q == TW_W'(TW_CYCLES - 1)) begin
        busy_d = 1'b0;
        latch_d = 1'b0;
        if (kind_q) begin
          lock_d = pend_q[2];
          region_d = pend_q[1:0];
        end
      end else begin
        tw_d = tw_q + TW_W'(1);
      end
    end

    if (ARRAY_WR_REQ) begin
      if (latch_q && !busy_q && !region_hit(ARRAY_WR_ADDR, region_q)) begin
        grant_d = 1'b1;
        busy_d = 1'b1;
        kind_d = 1'b0;
        tw_d = '0;
      end else begin
        deny_d = 1'b1;
      end
    end

    if (cs_rise) begin
      st_d = D_IDLE;
      if (st_q == D_WAIT) begin
        latch_d = arm_q;
      end else if (st_q == D_WEND) begin
        if (latch_q && !busy_q && !hard_lock && !grant_d) begin
          busy_d = 1'b1;
          kind_d = 1'b1;
          tw_d = '0;
          // only lock and region bits taken
          pend_d = {sh_q[BIT_LOCK], sh_q[BIT_LOCK_HI], sh_q[BIT_LOCK_LO]};
        end
      end
    end else if (cs_fall) begin
      st_d = D_OPC;
      cnt_d = 3'h0;
    end else if (sck_rise) begin
      unique case (st_q)
        D_OPC: begin
          sh_d = {sh_q[6:0], mosi_s};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            case (sh_d)
              OP_ARM_WRITE: begin
                st_d = D_WAIT;
                arm_d = 1'b1;
              end
              OP_DISARM_WRITE: begin
                st_d = D_WAIT;
                arm_d = 1'b0;
              end
              OP_STATUS_READ: begin
                st_d = D_CMD_STATUS_READ;
                tx_d = status_now;
              end
              OP_STATUS_WRITE: st_d = D_CMD_STATUS_WRITE;
              default: st_d = D_DESEL;
            endcase
          end
        end
        D_CMD_STATUS_WRITE: begin
          sh_d = {sh_q[6:0], mosi_s};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            st_d = D_WEND;
          end
        end
        D_WAIT, D_WEND: st_d = D_DESEL;
        D_IDLE, D_CMD_STATUS_READ, D_DESEL: st_d = st_q;
      endcase
    end else if (sck_fall && st_q == D_CMD_STATUS_READ) begin
      miso_d = tx_q[7];
      tx_d = (cnt_q == 3'h7) ? status_now : {tx_q[6:0], 1'b0};
      cnt_d = cnt_q + 3'h1;
    end

    status_d = status_now;
  end

  // nv bits reset to the delivery state; there is no storage across power
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q <= D_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      miso_q <= 1'b0;
      arm_q <= 1'b0;
      cs_p_q <= 1'b0;
      sclk_p_q <= 1'b0;
      latch_q <= 1'b0;
      busy_q <= 1'b0;
      kind_q <= 1'b0;
      tw_q <= '0;
      pend_q <= 3'h0;
      lock_q <= LOCK_RST;
      region_q <= REGION_RST;
      ARRAY_WR_GRANT <= 1'b0;
      ARRAY_WR_DENY <= 1'b0;
      STATUS <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      miso_q <= miso_d;
      arm_q <= arm_d;
      cs_p_q <= cs_p_d;
      sclk_p_q <= sclk_p_d;
      latch_q <= latch_d;
      busy_q <= busy_d;
      kind_q <= kind_d;
      tw_q <= tw_d;
      pend_q <= pend_d;
      lock_q <= lock_d;
      region_q <= region_d;
      ARRAY_WR_GRANT <= grant_d;
      ARRAY_WR_DENY <= deny_d;
      STATUS <= status_d;
    end
  end

  assign LINK.miso = miso_q;
endmodule : eesp_dev

// ==== logic/eesp_host.sv ====
`timescale 1ns/1ps
module eesp_host (
  input wire logic CORE_CLK,
  input wire logic RST,
  eesp_link_if.host LINK,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  import eesp_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_HIGH = 3'b010,
    H_LOW = 3'b011,
    H_GAP = 3'b100
  } eesp_hst_t;

  logic miso_s;

  eesp_sync #(.W(1)) u_sync (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .ASYNC_IN(LINK.miso),
    .SYNC_OUT(miso_s)
  );

  eesp_hst_t st_q, st_d;
  logic [3:0] hc_q, hc_d;
  logic [7:0] left_q, left_d;
  logic [15:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic sclk_q, sclk_d;
  logic cs_n_q, cs_n_d;
  logic mosi_q, mosi_d;
  logic wait_d;
  logic [31:0] rdata_d;
  logic guard_q, guard_d;
  logic start;
  logic tick;
  logic [7:0] op;
  logic [3:0] polls;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then a single cycle with waitrequest low

  assign start = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CMD && st_q == H_IDLE;

  always_comb begin
    wait_d = 1'b1;
    rdata_d = AVS_READDATA;
    guard_d = guard_q;
    if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
      wait_d = 1'b0;
      unique case (AVS_ADDRESS)
        REG_STAT: rdata_d = {16'h0000, rx_q, 7'h00, st_q != H_IDLE};
        REG_GUARD: rdata_d = {31'h00000000, guard_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_GUARD) begin
      guard_d = AVS_WRITEDATA[0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      guard_q <= GUARD_RST;
    end else begin
      AVS_WAITREQUEST <= wait_d;
      AVS_READDATA <= rdata_d;
      guard_q <= guard_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial engine, mode 0: data changes on fall, sampled on rise

  always_comb begin
    op = AVS_WRITEDATA[CMD_OP_LSB +: 8];
    polls = AVS_WRITEDATA[CMD_CNT_LSB +: 4];
    tick = (hc_q == 4'(SCLK_HALF - 1));
    st_d = st_q;
    hc_d = (tick || st_q == H_IDLE) ? 4'h0 : hc_q + 4'h1;
    left_d = left_q;
    tx_d = tx_q;
    rx_d = rx_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    mosi_d = mosi_q;
    unique case (st_q)
      H_IDLE: begin
        if (start) begin
          st_d = H_LEAD;
          cs_n_d = 1'b0;
          mosi_d = op[7];
          tx_d = {op[6:0], AVS_WRITEDATA[CMD_DATA_LSB +: 8], 1'b0};
          if (op == OP_STATUS_WRITE) begin
            left_d = 8'h10;
          end else if (op == OP_STATUS_READ) begin
            // a zero count still reads one byte
            left_d = 8'h08 + {1'b0, (polls == 4'h0) ? 4'h1 : polls, 3'h0};
          end else begin
            left_d = 8'h08;
          end
        end
      end
      H_LEAD, H_LOW: begin
        if (tick) begin
          st_d = H_HIGH;
          sclk_d = 1'b1;
          rx_d = {rx_q[6:0], miso_s};
          left_d = left_q - 8'h01;
        end
      end
      H_HIGH: begin
        if (tick) begin
          sclk_d = 1'b0;
          if (left_q == 8'h00) begin
            // deselect before the next rise keeps writes framed
            cs_n_d = 1'b1;
            st_d = H_GAP;
          end else begin
            mosi_d = tx_q[15];
            tx_d = {tx_q[14:0], 1'b0};
            st_d = H_LOW;
          end
        end
      end
      H_GAP: begin
        if (tick) begin
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q <= H_IDLE;
      hc_q <= 4'h0;
      left_q <= 8'h00;
      tx_q <= 16'h0000;
      rx_q <= 8'h00;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hc_q <= hc_d;
      left_q <= left_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      mosi_q <= mosi_d;
    end
  end

  assign LINK.cs_n = cs_n_q;
  assign LINK.sclk = sclk_q;
  assign LINK.mosi = mosi_q;
  assign LINK.wp_n = guard_q;
endmodule : eesp_host

// ==== test/eesp_link_sva.sv ====
`timescale 1ns/1ps
module eesp_link_sva (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic wp_n
);
  logic sclk_q;
  logic sclk_d;
  logic [4:0] bits_q;
  logic [4:0] bits_d;
  ////////////////////////////////////////////////////////////////////////////////
  // rises of sclk since select fell; only the low three bits matter
  always_comb begin
    sclk_d = sclk;
    bits_d = cs_n ? 5'h00 : bits_q + {4'h0, sclk & ~sclk_q};
  end
  always_ff @(posedge CORE_CLK) begin
    sclk_q <= RST ? 1'b0 : sclk_d;
    bits_q <= RST ? 5'h00 : bits_d;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_reset_idle_pins: assert property ($fell(RST) |-> cs_n && !sclk && !miso && wp_n)
    else $error("link pins not idle after reset");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase not eight cycles");
  a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low phase too short");
  a_mosi_steady: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_clock_selected: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_byte_frame: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0)
    else $error("select raised off a byte boundary");
  a_miso_steady: assert property ($rose(sclk) |-> $stable(miso) [*4])
    else $error("miso moved around sclk rise");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("gap between frames too short");
endmodule : eesp_link_sva

// ==== test/eeprom_status_protect_cmds_tb_top.sv ====
`timescale 1ns/1ps
module eeprom_status_protect_cmds_tb_top;
  import eesp_pkg::*;
  // short write cycle so a status read still fits inside it
  localparam int TW = 1000;
  localparam logic [ADDR_W-1:0] ADS [4] = '{17'h00000, 17'h0ffff, 17'h10000, 17'h18000};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wr_req = 1'b0;
  logic [ADDR_W-1:0] wr_addr = 17'h00000;
  logic wr_grant;
  logic wr_deny;
  logic [7:0] status;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  eesp_link_if link ();
  eesp_host eesp_host_i (.CORE_CLK(core_clk), .RST(rst), .LINK(link),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest));
  eesp_dev #(.TW_CYCLES(TW)) eesp_dev_i (.CORE_CLK(core_clk), .RST(rst), .LINK(link),
    .ARRAY_WR_REQ(wr_req), .ARRAY_WR_ADDR(wr_addr), .ARRAY_WR_GRANT(wr_grant),
    .ARRAY_WR_DENY(wr_deny), .STATUS(status));
  eesp_link_sva eesp_link_sva_i (.CORE_CLK(core_clk), .RST(rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .wp_n(link.wp_n));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // hang guard, well above the roughly 27k cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  // one avalon transfer; request held until waitrequest is sampled low
  // only the hang guard ends a wait for the answer
  task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : av
  // issue one frame and wait for the engine to go idle
  task cmd(input logic [7:0] op, input logic [7:0] d, input logic [3:0] cnt);
    logic [31:0] q;
    int k;
    av(1'b1, REG_CMD, {12'h000, cnt, d, op}, q);
    q = 32'h1;
    k = 0;
    while (q[0] !== 1'b0 && k < 300) begin
      av(1'b0, REG_STAT, 32'h0, q);
      k++;
    end
  endtask : cmd
  // busy shows a few cycles after select rises, so settle first
  task wait_idle(output int n);
    repeat (8) @(posedge core_clk);
    n = 0;
    while (status[0] !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_idle
  task sw(input logic [7:0] d);
    int n;
    cmd(OP_ARM_WRITE, 8'h00, 4'h0);
    cmd(OP_STATUS_WRITE, d, 4'h0);
    wait_idle(n);
  endtask : sw
  // grant or deny stands for the one cycle after the request is sampled
  task req(input logic [ADDR_W-1:0] a);
    wr_addr <= a;
    wr_req <= 1'b1;
    @(posedge core_clk);
    wr_req <= 1'b0;
    #1;
  endtask : req
  ////////////////////////////////////////////////////////////////////////////////
  task t_latch();
    logic [31:0] q;
    check(32'(status), 32'h0);
    av(1'b0, REG_GUARD, 32'h0, q);
    check(q, 32'h1);
    av(1'b0, 4'hc, 32'h0, q);
    check(q, 32'h0);
    av(1'b1, REG_CMD, {24'h0, OP_ARM_WRITE}, q);
    repeat (64) @(posedge core_clk);
    check(32'(status[BIT_LATCH]), 32'h0);
    // a command write while the engine runs is ignored, so let it finish
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      av(1'b0, REG_STAT, 32'h0, q);
    end
    cmd(OP_DISARM_WRITE, 8'h00, 4'h0);
    cmd(OP_ARM_WRITE, 8'h00, 4'h0);
    repeat (8) @(posedge core_clk);
    check(32'(status[BIT_LATCH]), 32'h1);
    cmd(8'hff, 8'h00, 4'h0);
    cmd(OP_STATUS_READ, 8'h00, 4'h1);
    av(1'b0, REG_STAT, 32'h0, q);
    check(32'(q[15:8]), 32'h02);
    cmd(OP_DISARM_WRITE, 8'h00, 4'h0);
    repeat (8) @(posedge core_clk);
    check(32'(status), 32'h0);
    cmd(OP_STATUS_WRITE, 8'h0c, 4'h0);
    repeat (8) @(posedge core_clk);
    check(32'(status), 32'h0);
  endtask : t_latch
  task t_status_write();
    logic [31:0] q;
    int n;
    cmd(OP_ARM_WRITE, 8'h00, 4'h0);
    cmd(OP_STATUS_WRITE, 8'h7b, 4'h0);
    repeat (8) @(posedge core_clk);
    check(32'(status), 32'h03);
    cmd(OP_STATUS_READ, 8'h00, 4'h3);
    av(1'b0, REG_STAT, 32'h0, q);
    check(32'(q[15:8]), 32'h03);
    wait_idle(n);
    check(32'(status), 32'h08);
  endtask : t_status_write
  task t_array();
    logic pr;
    int n;
    for (int c = 0; c < 4; c++) begin
      sw({4'h0, 2'(c), 2'h0});
      for (int i = 0; i < 4; i++) begin
        cmd(OP_ARM_WRITE, 8'h00, 4'h0);
        repeat (4) @(posedge core_clk);
        pr = c == 3 || (c == 2 && ADS[i] >= HALF_BASE) || (c == 1 && ADS[i] >= QUARTER_BASE);
        req(ADS[i]);
        check(32'({wr_grant, wr_deny}), 32'({!pr, pr}));
        wait_idle(n);
        if (!pr) begin
          check(32'(n > TW - 12 && n <= TW), 32'h1);
          check(32'(status[BIT_LATCH]), 32'h0);
        end
      end
    end
    sw(8'h00);
    req(17'h00000);
    check(32'({wr_grant, wr_deny}), 32'h1);
    @(posedge core_clk);
  endtask : t_array
  // guard pin low is hard lock only while the lock bit is set
  task t_hard_lock();
    logic [31:0] q;
    av(1'b1, REG_GUARD, 32'h0, q);
    sw(8'h80);
    check(32'(status), 32'h80);
    sw(8'h00);
    check(32'(status), 32'h82);
    av(1'b1, REG_GUARD, 32'h1, q);
    sw(8'h84);
    check(32'(status), 32'h84);
    av(1'b1, REG_GUARD, 32'h0, q);
    sw(8'h80);
    check(32'(status), 32'h86);
    av(1'b1, REG_GUARD, 32'h1, q);
    sw(8'h00);
    check(32'(status), 32'h00);
  endtask : t_hard_lock
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_latch();
    t_status_write();
    t_array();
    t_hard_lock();
    final_report();
  end
endmodule : eeprom_status_protect_cmds_tb_top
